// [shared/ffo_map.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the
 * flag offset load, offset readback and retransmit control block.
 * Assumes a 200 MHz bus clock and an AHB-Lite word-addressed register map.
 */
`ifndef FFO_MAP_SVH
`define FFO_MAP_SVH

`define FFO_REG_CTRL 8'h00
`define FFO_REG_STATUS 8'h04
`define FFO_REG_EOFF 8'h08
`define FFO_REG_FOFF 8'h0C
`define FFO_CTRL_LARGE_BIT 0

`define FFO_OFF_W 15
`define FFO_LO_W 9
`define FFO_HI_W 6
`define FFO_W_SMALL 5'h0E
`define FFO_W_LARGE 5'h0F
`define FFO_BITS_SMALL 5'h1C
`define FFO_BITS_LARGE 5'h1E
`define FFO_MASK_SMALL 15'h3FFF
`define FFO_MASK_LARGE 15'h7FFF
`define FFO_DFLT_SERIAL 15'h03FF
`define FFO_DFLT_PAR 15'h007F

`define FFO_FLAG_EDGES 2'h2
`define FFO_RT_LAST 2'h1
`define FFO_CLK_NS 5
`define FFO_SKEW_NS 10
`define FFO_SKEW_CYC ((`FFO_SKEW_NS + `FFO_CLK_NS - 1) / `FFO_CLK_NS)

`endif

// [shared/ffo_pkg.sv]
/*
 * Types of the flag offset control block: the bundle of device pins and the
 * retransmit sequencer states.
 * Assumes the constants of ffo_map.svh.
 */
package ffo_pkg;

    typedef struct packed {
        logic wclk;
        logic rclk;
        logic ld_n;
        logic sen_n;
        logic si;
        logic wen_n;
        logic ren_n;
        logic rt_n;
        logic mrs_n;
        logic prs_n;
        logic [8:0] data;
    } ffo_pins_t;

    typedef enum logic {
        ffo_rt_idle,
        ffo_rt_setup
    } ffo_rt_state_t;

endpackage

// [rtl/ffo_ctrl.sv]
/*
 * Flag offset load (serial and parallel), offset readback and retransmit
 * sequencing of a dual-clock FIFO, with an AHB-Lite register window.
 * Assumes all device pins, write and read clocks included, are asynchronous
 * to hclk and slower than a quarter of it; they are synchronised here.
 */
`timescale 1ns/10ps
`include "ffo_map.svh"

module ffo_ctrl
    import ffo_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Device pins from the controlling logic
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic offset_load_select_n,
    input wire logic serial_shift_enable_n,
    input wire logic fall_through_select_pin,
    input wire logic write_enable_n,
    input wire logic read_enable_n,
    input wire logic replay_request_n,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic [8:0] data_in_bus,
    // Offset readback
    output logic [8:0] data_out_bus,
    output logic offset_read_strobe,
    // Flag validity and mode
    output logic almost_empty_valid,
    output logic almost_full_valid,
    output logic serial_mode,
    output logic fall_through_mode,
    // Retransmit sequencing
    output logic empty_flag_n,
    output logic output_ready_n,
    output logic read_ptr_rewind,
    output logic first_word_show,
    output logic half_full_update,
    output logic almost_empty_update,
    output logic almost_full_update
);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and clock edge detection

    ffo_pins_t pin_raw;
    ffo_pins_t sync1;
    ffo_pins_t sync2;
    logic wclk_d;
    logic rclk_d;

    assign pin_raw = '{wclk: write_clk, rclk: read_clk, ld_n: offset_load_select_n,
                       sen_n: serial_shift_enable_n, si: fall_through_select_pin,
                       wen_n: write_enable_n, ren_n: read_enable_n, rt_n: replay_request_n,
                       mrs_n: master_reset_n, prs_n: partial_reset_n, data: data_in_bus};

    // Resets start asserted so nothing acts before the pins are seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            wclk_d <= sync2.wclk;
            rclk_d <= sync2.rclk;
        end
    end

    wire w_rise = sync2.wclk & ~wclk_d;
    wire r_rise = sync2.rclk & ~rclk_d;
    wire mrs_act = ~sync2.mrs_n;
    wire prs_act = ~sync2.prs_n;
    wire ld_lo = ~sync2.ld_n;
    wire sen_lo = ~sync2.sen_n;
    wire wen_lo = ~sync2.wen_n;
    wire ren_lo = ~sync2.ren_n;
    wire rt_lo = ~sync2.rt_n;

    ////////////////////////////////////////////////////////////////////////
    // Variant selection from software

    logic ctrl_large;
    wire [4:0] off_w = ctrl_large ? `FFO_W_LARGE : `FFO_W_SMALL;
    wire [4:0] bit_total = ctrl_large ? `FFO_BITS_LARGE : `FFO_BITS_SMALL;
    wire [14:0] off_mask = ctrl_large ? `FFO_MASK_LARGE : `FFO_MASK_SMALL;

    ////////////////////////////////////////////////////////////////////////
    // Offset registers, serial and parallel load

    logic [14:0] eoff;
    logic [14:0] foff;
    logic [4:0] bit_cnt;
    logic [1:0] wptr;
    logic [1:0] rptr;
    wire [14:0] e_hit;
    wire [14:0] f_hit;

    wire ser_shift = w_rise & serial_mode & ld_lo & sen_lo & ~mrs_act;
    wire ser_last = bit_cnt == bit_total - 5'h01;
    wire ser_done = ser_shift & ser_last;
    wire ser_first = ser_shift & (bit_cnt == 5'h00);
    wire par_wr = w_rise & ~serial_mode & ld_lo & wen_lo & ~mrs_act;
    wire par_el = par_wr & (wptr == 2'h0);
    wire par_eh = par_wr & (wptr == 2'h1);
    wire par_fl = par_wr & (wptr == 2'h2);
    wire par_fh = par_wr & (wptr == 2'h3);

    // Serial bits walk empty offset LSB first, then full offset
    for (genvar i = 0; i < `FFO_OFF_W; i++) begin : g_bit
        assign e_hit[i] = ser_shift & (bit_cnt == 5'(i)) & (5'(i) < off_w);
        assign f_hit[i] = ser_shift & (bit_cnt == off_w + 5'(i));
    end

    wire [14:0] dflt = sync2.ld_n ? `FFO_DFLT_SERIAL : `FFO_DFLT_PAR;
    wire [14:0] ser_e = (eoff & ~e_hit) | ({15{sync2.si}} & e_hit);
    wire [14:0] ser_f = (foff & ~f_hit) | ({15{sync2.si}} & f_hit);
    wire [14:0] lo_e = {eoff[14:`FFO_LO_W], sync2.data};
    wire [14:0] hi_e = {sync2.data[`FFO_HI_W-1:0], eoff[`FFO_LO_W-1:0]};
    wire [14:0] lo_f = {foff[14:`FFO_LO_W], sync2.data};
    wire [14:0] hi_f = {sync2.data[`FFO_HI_W-1:0], foff[`FFO_LO_W-1:0]};
    wire [14:0] next_eoff = (mrs_act ? dflt : par_el ? lo_e : par_eh ? hi_e : ser_e) & off_mask;
    wire [14:0] next_foff = (mrs_act ? dflt : par_fl ? lo_f : par_fh ? hi_f : ser_f) & off_mask;

    // Strap levels are caught while master reset is held, not at hresetn
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_mode <= 1'b0;
            fall_through_mode <= 1'b0;
            eoff <= '0;
            foff <= '0;
            bit_cnt <= '0;
            wptr <= '0;
        end else begin
            if (mrs_act) begin
                serial_mode <= sync2.ld_n;
                fall_through_mode <= sync2.si;
                bit_cnt <= '0;
                wptr <= '0;
            end else begin
                if (ser_shift)
                    bit_cnt <= ser_last ? 5'h00 : bit_cnt + 5'h01;
                if (par_wr)
                    wptr <= wptr + 2'h1;
            end
            eoff <= next_eoff;
            foff <= next_foff;
        end
    end

    chk_serial_hold: assert property (w_rise && serial_mode && ld_lo && !sen_lo && !mrs_act
        |=> $stable(bit_cnt) && $stable(eoff) && $stable(foff))
        else $error("serial shift with enable high");
    chk_serial_wrap: assert property (ser_done |=> bit_cnt == 5'h00)
        else $error("serial count did not wrap at set length");
    chk_par_order: assert property (par_wr && wptr == 2'h3 |=> wptr == 2'h0 && foff[14:9] ==
        ($past(sync2.data[5:0]) & off_mask[14:9]))
        else $error("parallel write order wrong");
    chk_mrs_ptrs: assert property (mrs_act |=> wptr == 2'h0 && rptr == 2'h0)
        else $error("pointers not cleared by master reset");

    ////////////////////////////////////////////////////////////////////////
    // Flag validity after offset loading

    logic [1:0] ae_wait;
    logic [1:0] af_wait;
    wire ae_start = ser_done | par_eh;
    wire af_start = ser_done | par_fh;
    wire ae_clear = ser_first | par_el;
    wire af_clear = ser_first | par_fl;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            almost_empty_valid <= 1'b0;
            almost_full_valid <= 1'b0;
            ae_wait <= '0;
            af_wait <= '0;
        end else if (mrs_act) begin
            almost_empty_valid <= 1'b1;
            almost_full_valid <= 1'b1;
            ae_wait <= '0;
            af_wait <= '0;
        end else begin
            if (ae_start) begin
                almost_empty_valid <= 1'b0;
                ae_wait <= `FFO_FLAG_EDGES;
            end else if (ae_clear) begin
                almost_empty_valid <= 1'b0;
                ae_wait <= '0;
            end else if (r_rise && ae_wait != 2'h0) begin
                ae_wait <= ae_wait - 2'h1;
                almost_empty_valid <= ae_wait == 2'h1;
            end
            if (af_start) begin
                almost_full_valid <= 1'b0;
                af_wait <= `FFO_FLAG_EDGES;
            end else if (af_clear) begin
                almost_full_valid <= 1'b0;
                af_wait <= '0;
            end else if (w_rise && af_wait != 2'h0) begin
                af_wait <= af_wait - 2'h1;
                almost_full_valid <= af_wait == 2'h1;
            end
        end
    end

    chk_af_valid_time: assert property ($rose(almost_full_valid) && !$past(mrs_act)
        |-> $past(w_rise) && $past(af_wait) == 2'h1)
        else $error("almost-full valid at wrong write edge");
    chk_ae_valid_time: assert property ($rose(almost_empty_valid) && !$past(mrs_act)
        |-> $past(r_rise) && $past(ae_wait) == 2'h1)
        else $error("almost-empty valid at wrong read edge");
    chk_ser_invalid: assert property (ser_done |=> !almost_empty_valid && !almost_full_valid)
        else $error("flag valid right at serial completion");

    ////////////////////////////////////////////////////////////////////////
    // Parallel offset readback

    wire off_rd = r_rise & ld_lo & ren_lo & ~mrs_act;
    wire [8:0] rd_word = (rptr == 2'h0) ? eoff[`FFO_LO_W-1:0] :
                         (rptr == 2'h1) ? {3'h0, eoff[14:`FFO_LO_W]} :
                         (rptr == 2'h2) ? foff[`FFO_LO_W-1:0] : {3'h0, foff[14:`FFO_LO_W]};

    // Readback only ever comes out on the parallel bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rptr <= '0;
            data_out_bus <= '0;
            offset_read_strobe <= 1'b0;
        end else begin
            offset_read_strobe <= off_rd;
            if (mrs_act)
                rptr <= '0;
            else if (off_rd)
                rptr <= rptr + 2'h1;
            if (off_rd)
                data_out_bus <= rd_word;
        end
    end

    chk_readback_data: assert property (off_rd |=> offset_read_strobe && data_out_bus == $past(rd_word))
        else $error("readback word not presented");
    chk_readback_hold: assert property (r_rise && !(ld_lo && ren_lo) && !mrs_act |=> $stable(rptr))
        else $error("read pointer moved while paused");
    chk_prs_ptrs: assert property (prs_act && !mrs_act && !par_wr && !off_rd |=> $stable(wptr) && $stable(rptr))
        else $error("partial reset moved a pointer");

    ////////////////////////////////////////////////////////////////////////
    // Retransmit sequencing

    ffo_rt_state_t rt_state;
    logic [1:0] rt_cnt;
    logic [3:0] rt_skew;
    logic [1:0] rt_wcnt;
    logic rt_af_busy;

    // The controller keeps both enables high here; requests are not qualified
    wire rt_take = r_rise & rt_lo & (rt_state == ffo_rt_idle) & ~mrs_act & ~prs_act;
    wire rt_step = r_rise & (rt_state == ffo_rt_setup);
    wire rt_end = rt_step & (rt_cnt == `FFO_RT_LAST);
    wire rt_af_edge = rt_af_busy & (rt_skew == 4'h0) & w_rise;
    ffo_rt_state_t next_rt_state;

    always_comb begin
        next_rt_state = rt_state;
        case (rt_state)
            ffo_rt_idle: begin
                if (rt_take)
                    next_rt_state = ffo_rt_setup;
            end
            ffo_rt_setup: begin
                if (rt_end)
                    next_rt_state = ffo_rt_idle;
            end
            default: next_rt_state = ffo_rt_idle;
        endcase
        if (mrs_act || prs_act)
            next_rt_state = ffo_rt_idle;
    end

    wire setup_next = next_rt_state == ffo_rt_setup;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_state <= ffo_rt_idle;
            rt_cnt <= '0;
            empty_flag_n <= 1'b1;
            output_ready_n <= 1'b0;
            read_ptr_rewind <= 1'b0;
            half_full_update <= 1'b0;
            almost_empty_update <= 1'b0;
            first_word_show <= 1'b0;
        end else begin
            rt_state <= next_rt_state;
            rt_cnt <= rt_take ? 2'h0 : rt_step ? rt_cnt + 2'h1 : rt_cnt;
            empty_flag_n <= ~(setup_next & ~fall_through_mode);
            output_ready_n <= setup_next & fall_through_mode;
            read_ptr_rewind <= rt_take;
            half_full_update <= rt_take;
            almost_empty_update <= rt_end & ~prs_act & ~mrs_act;
            first_word_show <= rt_end & fall_through_mode & ~prs_act & ~mrs_act;
        end
    end

    // Almost-full lives on the write clock, so wait out the skew first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_af_busy <= 1'b0;
            rt_skew <= '0;
            rt_wcnt <= '0;
            almost_full_update <= 1'b0;
        end else begin
            almost_full_update <= rt_af_edge & (rt_wcnt == `FFO_RT_LAST);
            if (mrs_act || prs_act) begin
                rt_af_busy <= 1'b0;
            end else if (rt_take) begin
                rt_af_busy <= 1'b1;
                rt_skew <= 4'(`FFO_SKEW_CYC);
                rt_wcnt <= '0;
            end else if (rt_af_busy && rt_skew != 4'h0) begin
                rt_skew <= rt_skew - 4'h1;
            end else if (rt_af_edge) begin
                rt_wcnt <= rt_wcnt + 2'h1;
                rt_af_busy <= rt_wcnt != `FFO_RT_LAST;
            end
        end
    end

    chk_rt_std_empty: assert property (rt_take && !fall_through_mode |=> !empty_flag_n && read_ptr_rewind)
        else $error("empty not low at retransmit setup");
    chk_rt_fall_through_mode_ready: assert property (rt_take && fall_through_mode
        |=> output_ready_n && half_full_update)
        else $error("output ready not high at retransmit setup");
    chk_rt_ae_second: assert property (rt_end && !prs_act && !mrs_act |=> almost_empty_update ##1 empty_flag_n)
        else $error("almost-empty update not on second read edge");
    chk_rt_af_skew: assert property (rt_take |=> !almost_full_update [*2])
        else $error("almost-full updated inside skew window");

    cov_serial_done: cover property (ser_done);
    cov_par_wrap: cover property (par_fh ##[1:200] par_el);
    cov_rt_fall_through_mode: cover property (rt_take && fall_through_mode ##[1:400] first_word_show);
    cov_readback: cover property (off_rd && rptr == 2'h3);

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite register window, zero wait states

    logic a_wr;
    logic [7:0] a_addr;
    wire acc = hsel & htrans[1] & hready;
    wire [31:0] status = {18'h0, bit_cnt, rptr, wptr, rt_state == ffo_rt_setup,
                          almost_full_valid, almost_empty_valid, fall_through_mode, serial_mode};
    wire [31:0] rd_bus = (haddr[7:0] == `FFO_REG_CTRL) ? {31'h0, ctrl_large} :
                         (haddr[7:0] == `FFO_REG_STATUS) ? status :
                         (haddr[7:0] == `FFO_REG_EOFF) ? {17'h0, eoff} :
                         (haddr[7:0] == `FFO_REG_FOFF) ? {17'h0, foff} : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_wr <= 1'b0;
            a_addr <= '0;
            hrdata <= '0;
            ctrl_large <= 1'b0;
        end else begin
            a_wr <= acc & hwrite;
            if (acc)
                a_addr <= haddr[7:0];
            if (acc && !hwrite)
                hrdata <= rd_bus;
            if (a_wr && a_addr == `FFO_REG_CTRL)
                ctrl_large <= hwdata[`FFO_CTRL_LARGE_BIT];
        end
    end

endmodule

// [test/ffo_pins.sv]
/* Controlling logic on the pin side of ffo_ctrl: pin clocks, strobes, data.
   Assumes the bench clock hclk; pin clocks stand low between cycles. */
`timescale 1ns/10ps
module ffo_pins (
    // Bench clock
    input wire logic hclk,
    // Device pins
    output logic write_clk,
    output logic read_clk,
    output logic offset_load_select_n,
    output logic serial_shift_enable_n,
    output logic fall_through_select_pin,
    output logic write_enable_n,
    output logic read_enable_n,
    output logic replay_request_n,
    output logic master_reset_n,
    output logic partial_reset_n,
    output logic [8:0] data_in_bus
);
    initial begin
        {write_clk, read_clk, fall_through_select_pin, data_in_bus} = '0;
        {offset_load_select_n, serial_shift_enable_n, write_enable_n} = '1;
        {read_enable_n, replay_request_n, master_reset_n, partial_reset_n} = '1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic hw(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Strobes {load, shift, write, read, replay} move only while clocks are low
    task automatic ctl(input logic [4:0] c);
        @(posedge hclk);
        {offset_load_select_n, serial_shift_enable_n, write_enable_n, read_enable_n, replay_request_n} <= c;
    endtask
    // Data is inverted once its hold has run out, so stale values never pass
    task automatic wcyc(input logic [8:0] d, input logic s);
        @(posedge hclk);
        data_in_bus <= d;
        fall_through_select_pin <= s;
        hw(4);
        write_clk <= 1'b1;
        hw(5);
        write_clk <= 1'b0;
        data_in_bus <= ~d;
        fall_through_select_pin <= ~s;
    endtask
    task automatic rcyc();
        hw(4);
        read_clk <= 1'b1;
        hw(5);
        read_clk <= 1'b0;
    endtask
    // Straps stay put for the whole pulse and past its synchroniser
    task automatic mreset(input logic ld, input logic ft);
        @(posedge hclk);
        offset_load_select_n <= ld;
        fall_through_select_pin <= ft;
        master_reset_n <= 1'b0;
        hw(6);
        master_reset_n <= 1'b1;
        hw(4);
    endtask
    task automatic preset();
        @(posedge hclk);
        partial_reset_n <= 1'b0;
        hw(6);
        partial_reset_n <= 1'b1;
        hw(4);
    endtask
endmodule

// [test/tb.sv]
/* Self-checking bench of ffo_ctrl: AHB-Lite master, pin traffic through
   ffo_pins, queue model of the offset words.
   Assumes pins are seen by the design 3 hclk after they change. */
`timescale 1ns/10ps
`include "ffo_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic write_clk, read_clk, offset_load_select_n, serial_shift_enable_n, fall_through_select_pin;
    logic write_enable_n, read_enable_n, replay_request_n, master_reset_n, partial_reset_n;
    logic [8:0] data_in_bus, data_out_bus;
    logic offset_read_strobe, almost_empty_valid, almost_full_valid, serial_mode, fall_through_mode;
    logic empty_flag_n, output_ready_n, read_ptr_rewind, first_word_show;
    logic half_full_update, almost_empty_update, almost_full_update;
    logic [4:0] ev;
    logic [29:0] sb;
    logic [14:0] eo, fo, mk;
    logic [8:0] pw[5];
    int fails, comparisons, i, v, md, n, w;
    int seed = 32'hcbf82814;
    int cnt[5] = '{default: 0};
    int base[5];
    int q[$];

    ffo_ctrl u_ffo_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .write_clk, .read_clk, .offset_load_select_n, .serial_shift_enable_n,
        .fall_through_select_pin, .write_enable_n, .read_enable_n, .replay_request_n, .master_reset_n,
        .partial_reset_n, .data_in_bus, .data_out_bus, .offset_read_strobe, .almost_empty_valid,
        .almost_full_valid, .serial_mode, .fall_through_mode, .empty_flag_n, .output_ready_n,
        .read_ptr_rewind, .first_word_show, .half_full_update, .almost_empty_update, .almost_full_update);
    ffo_pins u_ffo_pins (.hclk, .write_clk, .read_clk, .offset_load_select_n, .serial_shift_enable_n,
        .fall_through_select_pin, .write_enable_n, .read_enable_n, .replay_request_n, .master_reset_n,
        .partial_reset_n, .data_in_bus);

    ////////////////////////////////////////////////////////////////////////
    // Pulse counters, so one-cycle pulses are never missed between polls
    assign ev = {first_word_show, almost_full_update, almost_empty_update, half_full_update, read_ptr_rewind};
    always @(posedge hclk) begin
        for (int k = 0; k < 5; k++) begin
            cnt[k] <= cnt[k] + (ev[k] === 1'b1);
        end
    end
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic wrap_up();
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        int k;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'($random(seed)), a};
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
        r = hrdata;
        hsel <= 1'b0;
        if (hreadyout !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        logic [31:0] r;
        bus(1'b0, a, 32'($random(seed)), r);
        `CHK(s, e, r & m)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        // Serial sets of both variants, paused once for a memory write
        for (v = 0; v < 2; v++) begin
            u_ffo_pins.mreset(1'b1, 1'b0);
            rchk(8'h04, 32'hF, 32'hD, "status_serial");
            rchk(8'h08, 32'h7FFF, 32'h3FF, "eoff_default");
            rchk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
            bus(1'b1, 8'h00, {31'($random(seed)), 1'(v)}, rd);
            sb = 30'($random(seed));
            n = 28 + 2 * v;
            w = 14 + v;
            mk = v ? `FFO_MASK_LARGE : `FFO_MASK_SMALL;
            u_ffo_pins.ctl(5'b00111);
            for (i = 0; i < n; i++) begin
                if (i == 9) begin
                    u_ffo_pins.ctl(5'b01111);
                    u_ffo_pins.wcyc(9'h0, ~sb[i]);
                    u_ffo_pins.ctl(5'b11011);
                    u_ffo_pins.wcyc(9'h5A, 1'b0);
                    u_ffo_pins.ctl(5'b00111);
                end
                u_ffo_pins.wcyc(9'h0, sb[i]);
                if (i == 0) rchk(8'h04, 32'hC, 32'h0, "valid_mid_load");
            end
            u_ffo_pins.ctl(5'b11111);
            rchk(8'h08, 32'h7FFF, sb & mk, "eoff_serial");
            rchk(8'h0C, 32'h7FFF, (sb >> w) & mk, "foff_serial");
            rchk(8'h04, 32'h3E0C, 32'h0, "count_wrap");
            u_ffo_pins.wcyc(9'h0, 1'b0);
            u_ffo_pins.wcyc(9'h0, 1'b0);
            rchk(8'h04, 32'hC, 32'h8, "full_valid");
            u_ffo_pins.rcyc();
            u_ffo_pins.rcyc();
            rchk(8'h04, 32'hC, 32'hC, "empty_valid");
        end
        // Parallel writes with a memory write and a partial reset in the middle
        u_ffo_pins.mreset(1'b0, 1'b0);
        rchk(8'h0C, 32'h7FFF, 32'h7F, "foff_default");
        bus(1'b1, 8'h00, {31'($random(seed)), 1'b1}, rd);
        for (i = 0; i < 5; i++) pw[i] = 9'($random(seed));
        u_ffo_pins.ctl(5'b01011);
        for (i = 0; i < 5; i++) begin
            u_ffo_pins.wcyc(pw[i], 1'b0);
            if (i == 0) rchk(8'h04, 32'hC, 32'h8, "empty_invalid");
            if (i == 1) begin
                u_ffo_pins.ctl(5'b11011);
                u_ffo_pins.wcyc(9'h33, 1'b0);
                u_ffo_pins.preset();
                rchk(8'h04, 32'h1E0, 32'h40, "ptrs_kept");
                u_ffo_pins.ctl(5'b01011);
            end
        end
        eo = {pw[1][5:0], pw[4]};
        fo = {pw[3][5:0], pw[2]};
        rchk(8'h08, 32'h7FFF, eo, "eoff_par");
        rchk(8'h0C, 32'h7FFF, fo, "foff_par");
        // Readback from its own pointer, paused once
        q = {eo[8:0], eo[14:9], fo[8:0], fo[14:9], eo[8:0]};
        u_ffo_pins.ctl(5'b01101);
        for (i = 0; i < 5; i++) begin
            if (i == 2) begin
                u_ffo_pins.ctl(5'b01111);
                u_ffo_pins.rcyc();
                u_ffo_pins.ctl(5'b01101);
            end
            u_ffo_pins.rcyc();
            `CHK("readback", 9'(q[i]), data_out_bus)
        end
        // Replay in standard then fall-through timing
        for (md = 0; md < 2; md++) begin
            u_ffo_pins.mreset(1'b1, md[0]);
            `CHK("ft_mode", md[0], fall_through_mode)
            u_ffo_pins.ctl(5'b11011);
            u_ffo_pins.wcyc(9'h11, 1'b0);
            base = cnt;
            u_ffo_pins.ctl(5'b11110);
            u_ffo_pins.rcyc();
            u_ffo_pins.ctl(5'b11111);
            `CHK("setup_flag", md[0], (md ? output_ready_n : empty_flag_n))
            u_ffo_pins.wcyc(9'h0, 1'b0);
            u_ffo_pins.wcyc(9'h0, 1'b0);
            `CHK("setup_hold", md[0], (md ? output_ready_n : empty_flag_n))
            u_ffo_pins.rcyc();
            u_ffo_pins.rcyc();
            u_ffo_pins.hw(2);
            `CHK("setup_end", ~md[0], (md ? output_ready_n : empty_flag_n))
            for (i = 0; i < 5; i++) `CHK("pulses", (i == 4) ? md : 1, cnt[i] - base[i])
        end
        wrap_up();
    end
endmodule
